// ===== gfs_pkg.sv
// Constants and types of the gating fault supervisor
package gfs_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RESTART_TIMEOUT_S = 120;
  localparam int unsigned TEACH_TIMEOUT_DS = 1500;   // 2.5 min in 0.1 s
  localparam int unsigned KEY_SKEW_MS = 4000;        // 4 s
  localparam int unsigned RESP_MAX_MS = 99;
  localparam int unsigned TICK_MS = 1;
  // Cycles per 1 ms tick, longest time rounds down
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned RESTART_TIMEOUT_MS = RESTART_TIMEOUT_S * 1000;
  localparam int unsigned TEACH_TIMEOUT_MS = TEACH_TIMEOUT_DS * 100;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  localparam logic [2:0] MODE_ONE = 3'h1;
  localparam logic [2:0] MODE_FIVE = 3'h5;

  // ----------------------------------------
  // Diagnostic codes hold the code number, class goes out on diag_class
  // ----------------------------------------
  localparam logic [1:0] CLS_NONE = 2'h0;
  localparam logic [1:0] CLS_LOCK = 2'h1;
  localparam logic [1:0] CLS_AUTO = 2'h2;
  localparam logic [1:0] CLS_NOTE = 2'h3;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_E78 = 8'h4e;
  localparam logic [7:0] CODE_E79 = 8'h4f;
  localparam logic [7:0] CODE_E80 = 8'h50;
  localparam logic [7:0] CODE_E87 = 8'h57;
  localparam logic [7:0] CODE_E92 = 8'h5c;
  localparam logic [7:0] CODE_U55 = 8'h37;
  localparam logic [7:0] CODE_U56 = 8'h38;
  localparam logic [7:0] CODE_U61 = 8'h3d;
  localparam logic [7:0] CODE_U62 = 8'h3e;
  localparam logic [7:0] CODE_U69 = 8'h45;
  localparam logic [7:0] CODE_U71 = 8'h47;
  localparam logic [7:0] CODE_U74 = 8'h4a;
  localparam logic [7:0] CODE_U75 = 8'h4b;
  localparam logic [7:0] CODE_U80 = 8'h50;
  localparam logic [7:0] CODE_U82 = 8'h52;

  typedef enum logic [1:0] {GFS_IDLE, GFS_RUN, GFS_LOCK} gfs_state_e;

endpackage

// ===== gfs_supervisor.sv
// Fault supervisor for the gating light curtain receiver
`timescale 1ns/100ps

module gfs_supervisor
  import gfs_pkg::*;
#(
  parameter int unsigned RESTART_MS = RESTART_TIMEOUT_MS,
  parameter int unsigned TEACH_MS = TEACH_TIMEOUT_MS,
  parameter int unsigned SKEW_MS = KEY_SKEW_MS,
  parameter int unsigned TICK_CY = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Controller pins
  input wire logic gating_control_input,
  input wire logic gating_hold_input,
  input wire logic reset_button,
  input wire logic teach_key_a,
  input wire logic teach_key_b,
  input wire logic [2:0] mode_setting,
  // Internal status from the sensor core
  input wire logic mode_valid,
  input wire logic gating_initiating,
  input wire logic gating_timeout,
  input wire logic channel_corrupt,
  input wire logic teach_active,
  input wire logic teach_done,
  input wire logic teach_floating,
  input wire logic [7:0] resp_time_ms,
  input wire logic teach_plausible,
  input wire logic teach_consistent,
  input wire logic safety_switching_output_request,
  // Results
  output logic safety_switching_output,
  output logic restart_interlock,
  output logic fault_locked,
  output logic [7:0] diag_code,
  output logic [1:0] diag_class
);

  // Counter widths bound the timing parameters
  if (TICK_CY == 32'h0 || TICK_CY > 32'h10000 ||
      RESTART_MS == 32'h0 || RESTART_MS > 32'h3ffff ||
      TEACH_MS == 32'h0 || TEACH_MS > 32'h3fffff ||
      SKEW_MS == 32'h0 || SKEW_MS > 32'h1fff) begin : g_bad_param
    $error("gfs_supervisor: timing parameter out of range");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  assign pin_raw = {mode_setting, teach_key_b, teach_key_a, reset_button,
                    gating_hold_input, gating_control_input};

  // A level counts once the second and third stage agree
  always_comb begin
    flt_d = flt_q;
    for (int i = 0; i < NPIN; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        flt_d[i] = s3_q[i];
      end
    end
  end

  // Kept out of reset, so start-up checks see settled pin levels
  always_ff @(posedge mclk) begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    flt_q <= flt_d;
  end

  logic cs, th, rb, ka, kb;
  logic [2:0] mode;
  assign {mode, kb, ka, rb, th, cs} = flt_q;

  // ----------------------------------------
  // Millisecond tick and counters
  // ----------------------------------------
  logic [15:0] div_q, div_d;
  logic tick_q, tick_d;
  logic [17:0] rst_ms_q, rst_ms_d;
  logic [21:0] teach_ms_q, teach_ms_d;
  logic [12:0] skew_ms_q, skew_ms_d;

  function automatic logic [21:0] sat_inc(input logic [21:0] v,
                                          input logic en);
    sat_inc = (en && v != '1) ? v + 22'h1 : v;
  endfunction

  always_comb begin
    tick_d = 1'b0;
    div_d = div_q + 16'h1;
    if (div_q == 16'(TICK_CY - 1)) begin
      div_d = '0;
      tick_d = 1'b1;
    end
    // Counters restart whenever their condition drops
    rst_ms_d = rb ? 18'(sat_inc(22'(rst_ms_q), tick_q)) : '0;
    teach_ms_d = teach_active ? sat_inc(teach_ms_q, tick_q) : '0;
    skew_ms_d = (ka ^ kb) ? 13'(sat_inc(22'(skew_ms_q), tick_q)) : '0;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      div_q <= '0;
      tick_q <= 1'b0;
      rst_ms_q <= '0;
      teach_ms_q <= '0;
      skew_ms_q <= '0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
      rst_ms_q <= rst_ms_d;
      teach_ms_q <= teach_ms_d;
      skew_ms_q <= skew_ms_d;
    end
  end

  // ----------------------------------------
  // Supervisor state
  // ----------------------------------------
  gfs_state_e st_q, st_d;
  logic [2:0] run_mode_q, run_mode_d;
  logic [7:0] lock_code_q, lock_code_d;
  logic [7:0] hold_code_q, hold_code_d;
  logic interlock_q, interlock_d;
  logic rb_prev_q, cs_prev_q, th_prev_q;
  logic startup_q, startup_d;
  logic rb_rise, rb_fall, rb_edge, other_edge;

  assign rb_rise = rb && !rb_prev_q;
  assign rb_fall = !rb && rb_prev_q;
  assign rb_edge = rb_rise || rb_fall;
  assign other_edge = (cs != cs_prev_q) || (th != th_prev_q);

  always_comb begin
    st_d = st_q;
    run_mode_d = run_mode_q;
    lock_code_d = lock_code_q;
    hold_code_d = hold_code_q;
    interlock_d = interlock_q;
    startup_d = 1'b0;
    unique case (st_q)
      GFS_IDLE: begin
        run_mode_d = mode;
        hold_code_d = CODE_NONE;
        if (!mode_valid || rb) begin
          st_d = GFS_LOCK;
          lock_code_d = CODE_E80;
        end else if (startup_q && cs) begin
          // Notice stands while the control input stays high
          hold_code_d = CODE_U80;
          startup_d = 1'b1;
        end else begin
          st_d = GFS_RUN;
        end
      end
      GFS_RUN: begin
        if (mode != run_mode_q || !mode_valid) begin
          st_d = GFS_LOCK;
          lock_code_d = (mode_valid) ? CODE_E87 : CODE_E80;
        end else if (run_mode_q == MODE_ONE && gating_initiating
                     && cs == th) begin
          st_d = GFS_LOCK;
          lock_code_d = CODE_E78;
        end else if (gating_timeout) begin
          st_d = GFS_LOCK;
          lock_code_d = CODE_E79;
        end
        if (rst_ms_q >= 18'(RESTART_MS)) begin
          hold_code_d = CODE_U55;
          interlock_d = 1'b1;
        end else if (rb_edge && other_edge) begin
          hold_code_d = CODE_U74;
          interlock_d = 1'b1;
        end else if (rb_fall) begin
          if ((run_mode_q == MODE_ONE && (cs || th)) ||
              (run_mode_q == MODE_FIVE && cs)) begin
            hold_code_d = CODE_U82;
          // restart needs a gating input
          // Mode one locks with E78 first, so this serves mode five
          end else if (!cs && !th && gating_initiating) begin
            hold_code_d = CODE_U56;
          end else begin
            hold_code_d = CODE_NONE;
            interlock_d = 1'b0;
          end
        end
        if (teach_ms_q >= 22'(TEACH_MS)) begin
          hold_code_d = CODE_U61;
          interlock_d = 1'b1;
        end else if (skew_ms_q >= 13'(SKEW_MS)) begin
          hold_code_d = CODE_U62;
          interlock_d = 1'b1;
        end else if (teach_done) begin
          if (teach_floating && resp_time_ms > 8'(RESP_MAX_MS)) begin
            hold_code_d = CODE_U69;
          end else if (!teach_plausible) begin
            hold_code_d = CODE_U71;
          end else if (!teach_consistent) begin
            hold_code_d = CODE_U75;
          end else begin
            hold_code_d = CODE_NONE;
          end
          interlock_d = 1'b1;
        end
      end
      GFS_LOCK: begin
        st_d = GFS_LOCK;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= GFS_IDLE;
      run_mode_q <= '0;
      lock_code_q <= CODE_NONE;
      hold_code_q <= CODE_NONE;
      interlock_q <= 1'b1;
      startup_q <= 1'b1;
      rb_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
      th_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      run_mode_q <= run_mode_d;
      lock_code_q <= lock_code_d;
      hold_code_q <= hold_code_d;
      interlock_q <= interlock_d;
      startup_q <= startup_d && startup_q;
      rb_prev_q <= rb;
      cs_prev_q <= cs;
      th_prev_q <= th;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic out_d, lock_d;
  logic [7:0] code_d;
  logic [1:0] cls_d;

  always_comb begin
    lock_d = (st_d == GFS_LOCK);
    // channel fault clears with its cause
    if (lock_d) begin
      code_d = lock_code_d;
      cls_d = CLS_LOCK;
    end else if (channel_corrupt) begin
      code_d = CODE_E92;
      cls_d = CLS_AUTO;
    end else if (hold_code_d != CODE_NONE) begin
      code_d = hold_code_d;
      cls_d = CLS_NOTE;
    end else begin
      code_d = CODE_NONE;
      cls_d = CLS_NONE;
    end
    // Any fault or notice holds the safety outputs off
    out_d = safety_switching_output_request && !lock_d && !channel_corrupt &&
            hold_code_d == CODE_NONE && !interlock_d &&
            st_d == GFS_RUN;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      safety_switching_output <= 1'b0;
      restart_interlock <= 1'b1;
      fault_locked <= 1'b0;
      diag_code <= CODE_NONE;
      diag_class <= CLS_NONE;
    end else begin
      safety_switching_output <= out_d;
      restart_interlock <= interlock_d;
      fault_locked <= lock_d;
      diag_code <= code_d;
      diag_class <= cls_d;
    end
  end

endmodule

// ===== gfs_supervisor_assertions.sv
// Concurrent checks on the gating fault supervisor ports
`timescale 1ns/100ps
module gfs_checker
  import gfs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Fault causes
  input wire logic gating_timeout,
  input wire logic channel_corrupt,
  input wire logic teach_done,
  input wire logic teach_floating,
  input wire logic [7:0] resp_time_ms,
  input wire logic teach_plausible,
  input wire logic teach_consistent,
  // Results
  input wire logic safety_switching_output,
  input wire logic restart_interlock,
  input wire logic fault_locked,
  input wire logic [7:0] diag_code,
  input wire logic [1:0] diag_class
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ----
  // Properties
  // ----
  property p_lock_off;
    fault_locked |-> !safety_switching_output && diag_class == CLS_LOCK;
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("output on or wrong class in lock");
  property p_hold; fault_locked |=> fault_locked; endproperty
  a_hold: assert property (p_hold)
    else $error("lock dropped without reset");
  property p_tmo;
    gating_timeout && !fault_locked |-> ##[1:4] diag_code == CODE_E79;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("no lock on gating timeout");
  property p_chan;
    channel_corrupt && !fault_locked |-> ##[1:4]
      (diag_code == CODE_E92 && !safety_switching_output);
  endproperty
  a_chan: assert property (p_chan)
    else $error("corrupt channel not reported");
  property p_clear;
    $fell(channel_corrupt) && !fault_locked |-> ##[1:4] diag_class != CLS_AUTO;
  endproperty
  a_clear: assert property (p_clear)
    else $error("self-clearing fault stayed");
  property p_data;
    teach_done && !(teach_plausible && teach_consistent) && !fault_locked
      |-> ##[1:4] (!safety_switching_output &&
      (diag_code == CODE_U71 || diag_code == CODE_U75));
  endproperty
  a_data: assert property (p_data)
    else $error("bad teach data not reported");
  property p_resp;
    teach_done && teach_plausible && teach_consistent && teach_floating &&
      resp_time_ms > 8'h63 && !fault_locked |-> ##[1:4] diag_code == CODE_U69;
  endproperty
  a_resp: assert property (p_resp)
    else $error("slow response not reported");
  property p_ilock; restart_interlock |-> !safety_switching_output; endproperty
  a_ilock: assert property (p_ilock)
    else $error("output on with interlock set");
  property p_note; diag_class == CLS_NOTE |-> !safety_switching_output; endproperty
  a_note: assert property (p_note)
    else $error("output on during notice");
  c_lock: cover property (fault_locked);
  c_auto: cover property (diag_class == CLS_AUTO);
  c_note: cover property (diag_class == CLS_NOTE);
  c_on: cover property (safety_switching_output);
endmodule

bind gfs_supervisor gfs_checker u_chk (
  .mclk, .srst, .gating_timeout, .channel_corrupt, .teach_done,
  .teach_floating, .resp_time_ms, .teach_plausible, .teach_consistent,
  .safety_switching_output, .restart_interlock, .fault_locked,
  .diag_code, .diag_class
);

// ===== gfs_ctl_model.sv
// Machine controller and operator button model
`timescale 1ns/100ps
module gfs_ctl_model (
  // Clock
  input wire logic mclk,
  // Controller and button pins
  output logic gating_control_input,
  output logic gating_hold_input,
  output logic reset_button,
  output logic teach_key_a,
  output logic teach_key_b,
  output logic [2:0] mode_setting
);
  // ----
  // Pin pattern: control, hold, reset, key a, key b, mode
  // ----
  initial {gating_control_input, gating_hold_input, reset_button,
    teach_key_a, teach_key_b, mode_setting} = 8'h01;
  task automatic put(input logic [7:0] p);
    @(posedge mclk);
    {gating_control_input, gating_hold_input, reset_button,
      teach_key_a, teach_key_b, mode_setting} <= p;
  endtask
  task automatic button(input logic v);
    @(posedge mclk);
    reset_button <= v;
  endtask
endmodule

// ===== gfs_supervisor_bench.sv
// Self-checking bench of the gating fault supervisor
`timescale 1ns/100ps
module gfs_supervisor_bench;
  import gfs_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cs, th, rb, ka, kb;
  logic [2:0] mode;
  logic valid, init, tmo, bad_ch;
  logic t_act, t_done, t_flt;
  logic plaus, cons, req;
  logic [7:0] resp;
  logic out, ilock, locked;
  logic [7:0] code;
  logic [1:0] cls;
  int bad_count = 0;
  int num_checks = 0;
  always #25 mclk = ~mclk;
  gfs_ctl_model u_ctl (.mclk, .gating_control_input(cs),
    .gating_hold_input(th), .reset_button(rb), .teach_key_a(ka),
    .teach_key_b(kb), .mode_setting(mode));
  // Short timer parameters keep the run brief
  gfs_supervisor #(.RESTART_MS(5), .TEACH_MS(5), .SKEW_MS(5), .TICK_CY(2))
  u_dut (.mclk, .srst, .gating_control_input(cs), .gating_hold_input(th),
    .reset_button(rb), .teach_key_a(ka), .teach_key_b(kb),
    .mode_setting(mode), .mode_valid(valid), .gating_initiating(init),
    .gating_timeout(tmo), .channel_corrupt(bad_ch), .teach_active(t_act),
    .teach_done(t_done), .teach_floating(t_flt), .resp_time_ms(resp),
    .teach_plausible(plaus), .teach_consistent(cons), .safety_switching_output_request(req),
    .safety_switching_output(out), .restart_interlock(ilock),
    .fault_locked(locked), .diag_code(code), .diag_class(cls));
  // ----
  // Helpers
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Pins pass a synchroniser, so wait a bounded span for the code
  task automatic state(input logic [7:0] c, input logic o);
    for (int n = 0; n < 90 && code !== c; n++) tick(1);
    check({code, out}, {c, o});
  endtask
  task automatic boot(input logic [7:0] p, input logic v);
    @(posedge mclk);
    srst <= 1'b1;
    {valid, init, tmo, bad_ch, t_act, t_done, t_flt, plaus, cons} <= {v, 8'h03};
    req <= 1'b1;
    resp <= 8'h0a;
    u_ctl.put(p);
    tick(15);
    check({code, out}, {CODE_NONE, 1'b0});
    check({8'h00, ilock}, 9'h001);
    @(posedge mclk);
    srst <= 1'b0;
    tick(12);
  endtask
  // Short press stays well inside the restart timeout
  task automatic press;
    u_ctl.button(1'b1);
    tick(4);
    u_ctl.button(1'b0);
    tick(12);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_boot;
    boot(8'h81, 1'b1);
    state(CODE_U80, 1'b0);
    check({7'h00, cls}, {7'h00, CLS_NOTE});
    boot(8'h01, 1'b0);
    state(CODE_E80, 1'b0);
    boot(8'h21, 1'b1);
    state(CODE_E80, 1'b0);
    check({7'h00, cls}, {7'h00, CLS_LOCK});
  endtask
  task automatic t_run;
    boot(8'h01, 1'b1);
    press();
    state(CODE_NONE, 1'b1);
    @(posedge mclk);
    req <= 1'b0;
    tick(2);
    check({code, out}, {CODE_NONE, 1'b0});
    @(posedge mclk);
    req <= 1'b1;
    tick(2);
    check({code, out}, {CODE_NONE, 1'b1});
    u_ctl.put(8'h05);
    state(CODE_E87, 1'b0);
    check({8'h00, locked}, 9'h001);
    u_ctl.put(8'h01);
    press();
    state(CODE_E87, 1'b0);
  endtask
  task automatic t_gate;
    boot(8'h01, 1'b1);
    press();
    @(posedge mclk);
    tmo <= 1'b1;
    state(CODE_E79, 1'b0);
    boot(8'h01, 1'b1);
    u_ctl.put(8'h81);
    tick(8);
    @(posedge mclk);
    init <= 1'b1;
    u_ctl.put(8'hc1);
    state(CODE_E78, 1'b0);
    boot(8'h01, 1'b1);
    press();
    @(posedge mclk);
    bad_ch <= 1'b1;
    state(CODE_E92, 1'b0);
    check({7'h00, cls}, {7'h00, CLS_AUTO});
    @(posedge mclk);
    bad_ch <= 1'b0;
    state(CODE_NONE, 1'b1);
    check({7'h00, cls}, {7'h00, CLS_NONE});
  endtask
  task automatic t_ack;
    logic [7:0] p [2] = '{8'h41, 8'h85};
    for (int i = 0; i < 2; i++) begin
      boot({5'h00, p[i][2:0]}, 1'b1);
      u_ctl.put(p[i]);
      press();
      state(CODE_U82, 1'b0);
      check({8'h00, ilock}, 9'h001);
    end
    boot(8'h05, 1'b1);
    @(posedge mclk);
    init <= 1'b1;
    press();
    state(CODE_U56, 1'b0);
    check({8'h00, ilock}, 9'h001);
  endtask
  task automatic t_timers;
    boot(8'h01, 1'b1);
    u_ctl.button(1'b1);
    state(CODE_U55, 1'b0);
    boot(8'h05, 1'b1);
    u_ctl.button(1'b1);
    tick(4);
    u_ctl.put(8'h45);
    state(CODE_U74, 1'b0);
    check({8'h00, ilock}, 9'h001);
    boot(8'h01, 1'b1);
    u_ctl.put(8'h11);
    state(CODE_U62, 1'b0);
    boot(8'h01, 1'b1);
    @(posedge mclk);
    t_act <= 1'b1;
    state(CODE_U61, 1'b0);
  endtask
  task automatic t_teach;
    logic [7:0] want [4] = '{CODE_U71, CODE_U75, CODE_U69, CODE_NONE};
    for (int i = 0; i < 4; i++) begin
      boot(8'h01, 1'b1);
      press();
      state(CODE_NONE, 1'b1);
      @(posedge mclk);
      t_act <= 1'b1;
      @(posedge mclk);
      {t_done, plaus, cons, t_flt} <= {1'b1, i != 0, i != 1, i > 1};
      resp <= (i == 2) ? 8'h64 : 8'h63;
      @(posedge mclk);
      {t_act, t_done} <= 2'h0;
      tick(10);
      state(want[i], 1'b0);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    results();
  end
  initial begin
    t_boot();
    t_run();
    t_gate();
    t_ack();
    t_timers();
    t_teach();
    results();
  end
endmodule
